// >>> logic/cmm_top.sv
// Converter mode control, spread spectrum, sync check and load meter.
`timescale 1ns/1ps
module cmm_top (
   input  wire logic        core_clk_i,
   input  wire logic        rstn_i,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [19:0] otp_vset_i,
   input  wire logic [1:0]  otp_fpwm_i,
   input  wire logic        otp_bypass_i,
   input  wire logic        input_overvoltage_choice_i,
   input  wire logic [8:0]  meter_code_i,
   input  wire logic [1:0]  buck_heavy_i,
   input  wire logic        sync_clock_input_i,
   output logic [1:0]       buck_pwm_o,
   output logic             step_up_pwm_o,
   output logic             step_up_discharge_o,
   output logic             step_up_bypass_o,
   output logic             input_overvoltage_choice_o,
   output logic [9:0]       spread_permille_o,
   output logic             use_sync_clock_o,
   output logic [19:0]      vset_o,
   output logic             irq_n_o
);
   // Byte-lane merge for register writes.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      return (old & ~m) | (nw & m);
   endfunction : merge

   // Edge-count bound for a rate in MHz scaled by a percentage.
   function automatic logic [11:0] bound(input logic [4:0] rate,
                                         input int pct);
      return 12'((int'(rate) * cmm_pkg::WIN_US * pct) / 100);
   endfunction : bound

   logic [15:0] ctrl_q;
   logic [19:0] vset_q;
   logic [1:0]  fpwm_q;
   logic        sel_q, flag_q, mask_q, busy_q, loaded_q;
   logic        bypass_q, ovp_q;
   logic [8:0]  res_q;
   logic [11:0] mcnt_q, run_q;
   logic        aw_q, w_q;
   logic [7:0]  awa_q;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;
   logic        wr_go, wr_hit, flag_clr, sel_wr, done;
   logic        ss_on;
   logic        valid_q;

   // Write channel: address and data taken in either order.
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign wr_go = aw_q && w_q && !s_axi_bvalid;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         awa_q <= 8'h00;
         wd_q  <= 32'h0000_0000;
         ws_q  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q  <= 1'b1;
            awa_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q  <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_q <= 1'b0;
         end
      end
   end

   // Decode of the write target.
   always_comb begin
      unique case ({awa_q[7:2], 2'b00})
         cmm_pkg::OFS_CTRL, cmm_pkg::OFS_VSET, cmm_pkg::OFS_SEL,
         cmm_pkg::OFS_FLAG, cmm_pkg::OFS_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // Write response; unmapped or read-only targets answer an error.
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= cmm_pkg::RESP_OK;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? cmm_pkg::RESP_OK : cmm_pkg::RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign sel_wr   = wr_go && awa_q == cmm_pkg::OFS_SEL && ws_q[0];
   assign flag_clr = wr_go && awa_q == cmm_pkg::OFS_FLAG && ws_q[0]
                     && wd_q[0];

   // Control and voltage registers; factory values load once.
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q   <= cmm_pkg::CTRL_RST;
         vset_q   <= cmm_pkg::VSET_RST;
         loaded_q <= 1'b0;
         mask_q   <= 1'b0;
      end else if (!loaded_q) begin
         loaded_q <= 1'b1;
         vset_q   <= otp_vset_i;
         ctrl_q[cmm_pkg::CT_FPWM1:cmm_pkg::CT_FPWM0] <= otp_fpwm_i;
      end else if (wr_go) begin
         if (awa_q == cmm_pkg::OFS_CTRL)
            ctrl_q <= 16'(merge({16'h0000, ctrl_q}, wd_q, ws_q))
                      & cmm_pkg::CTRL_MSK;
         if (awa_q == cmm_pkg::OFS_VSET)
            vset_q <= 20'(merge({12'h000, vset_q}, wd_q, ws_q));
         if (awa_q == cmm_pkg::OFS_MASK && ws_q[0])
            mask_q <= wd_q[0];
      end
   end

   // Factory-only bits are caught after reset and never rewritten.
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bypass_q <= 1'b0;
         ovp_q    <= 1'b0;
      end else if (!loaded_q) begin
         bypass_q <= otp_bypass_i;
         ovp_q    <= input_overvoltage_choice_i;
      end
   end

   // Meter sequence: a selection write restarts it.
   assign done = busy_q && mcnt_q == 12'(cmm_pkg::MEAS_CYC - 1);
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_q <= 1'b0;
         mcnt_q <= 12'h000;
         sel_q  <= 1'b0;
         res_q  <= 9'h000;
      end else if (sel_wr) begin
         busy_q <= 1'b1;
         mcnt_q <= 12'h000;
         sel_q  <= wd_q[0];
      end else if (done) begin
         busy_q <= 1'b0;
         res_q  <= meter_code_i;
      end else if (busy_q) begin
         mcnt_q <= mcnt_q + 12'h001;
      end
   end

   // Done flag: a new completion beats a clear in the same cycle.
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i)
         flag_q <= 1'b0;
      else if (done)
         flag_q <= 1'b1;
      else if (flag_clr)
         flag_q <= 1'b0;
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i)
         irq_n_o <= 1'b1;
      else
         irq_n_o <= !(flag_q && !mask_q);
   end

   // Read channel: answer one cycle after the address is taken.
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= cmm_pkg::RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= cmm_pkg::RESP_OK;
         unique case ({s_axi_araddr[7:2], 2'b00})
            cmm_pkg::OFS_CTRL: s_axi_rdata <= {16'h0000, ctrl_q};
            cmm_pkg::OFS_VSET: s_axi_rdata <= {12'h000, vset_q};
            cmm_pkg::OFS_SEL:  s_axi_rdata <= {31'h0, sel_q};
            cmm_pkg::OFS_FLAG: s_axi_rdata <= {31'h0, flag_q};
            cmm_pkg::OFS_MASK: s_axi_rdata <= {31'h0, mask_q};
            cmm_pkg::OFS_RLO:  s_axi_rdata <= {24'h0, res_q[7:0]};
            cmm_pkg::OFS_RHI:  s_axi_rdata <= {31'h0, res_q[8]};
            cmm_pkg::OFS_STAT: s_axi_rdata <= {25'h0, buck_pwm_o, ovp_q,
                                  bypass_q, valid_q, ss_on, busy_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= cmm_pkg::RESP_ERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Sync clock pin passes two flops before use.
   logic [2:0]  sy_q;
   logic [11:0] wcnt_q, ecnt_q;
   logic [4:0]  rate;
   logic        rate_ok, win_end;
   assign rate = ctrl_q[cmm_pkg::CT_RATE +: cmm_pkg::RATE_W];
   assign rate_ok = int'(rate) >= cmm_pkg::RATE_MIN
                    && int'(rate) <= cmm_pkg::RATE_MAX;
   assign win_end = wcnt_q == 12'(cmm_pkg::WIN_CYC - 1);
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sy_q   <= 3'b000;
         wcnt_q <= 12'h000;
         ecnt_q <= 12'h000;
         valid_q <= 1'b0;
      end else begin
         sy_q <= {sy_q[1:0], sync_clock_input_i};
         if (win_end) begin
            wcnt_q  <= 12'h000;
            ecnt_q  <= 12'h000;
            valid_q <= rate_ok
                       && ecnt_q >= bound(rate, cmm_pkg::TOL_LO)
                       && ecnt_q <= bound(rate, cmm_pkg::TOL_HI);
         end else begin
            wcnt_q <= wcnt_q + 12'h001;
            if (sy_q[1] && !sy_q[2])
               ecnt_q <= ecnt_q + 12'h001;
         end
      end
   end

   // Spread sweep: triangle between 850 and 1000 per mille.
   logic [5:0] div_q;
   logic       up_q;
   assign ss_on = ctrl_q[cmm_pkg::CT_SS] && !ctrl_q[cmm_pkg::CT_PLL];
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_q <= 6'h00;
         up_q  <= 1'b0;
         spread_permille_o <= 10'(cmm_pkg::SS_HIGH_PM);
      end else if (!ss_on) begin
         div_q <= 6'h00;
         up_q  <= 1'b0; // A restart sweeps down, never above 1000.
         spread_permille_o <= 10'(cmm_pkg::SS_HIGH_PM);
      end else if (div_q == 6'(cmm_pkg::SS_DIV - 1)) begin
         div_q <= 6'h00;
         if (up_q) begin
            spread_permille_o <= spread_permille_o + 10'h001;
            if (spread_permille_o == 10'(cmm_pkg::SS_HIGH_PM - 1))
               up_q <= 1'b0;
         end else begin
            spread_permille_o <= spread_permille_o - 10'h001;
            if (spread_permille_o == 10'(cmm_pkg::SS_LOW_PM + 1))
               up_q <= 1'b1;
         end
      end else begin
         div_q <= div_q + 6'h01;
      end
   end

   // Load comparator pins are synchronised before mode choice.
   logic [1:0] hv1_q, hv2_q;
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hv1_q <= 2'b00;
         hv2_q <= 2'b00;
      end else begin
         hv1_q <= buck_heavy_i;
         hv2_q <= hv1_q;
      end
   end

   // Converter mode and pin outputs.
   assign fpwm_q = ctrl_q[cmm_pkg::CT_FPWM1:cmm_pkg::CT_FPWM0];
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         buck_pwm_o    <= 2'b00;
         step_up_pwm_o <= 1'b1;
         step_up_discharge_o <= 1'b0;
         step_up_bypass_o    <= 1'b0;
         input_overvoltage_choice_o <= 1'b0;
         use_sync_clock_o <= 1'b0;
         vset_o <= cmm_pkg::VSET_RST;
      end else begin
         for (int i = 0; i < 2; i++)
            buck_pwm_o[i] <= fpwm_q[i]
                             || hv2_q[i]
                             || (busy_q && sel_q == 1'(i));
         step_up_pwm_o <= 1'b1;
         step_up_discharge_o <= !ctrl_q[cmm_pkg::CT_BST]
                                && ctrl_q[cmm_pkg::CT_DIS];
         step_up_bypass_o <= bypass_q;
         input_overvoltage_choice_o <= ovp_q;
         use_sync_clock_o <= ctrl_q[cmm_pkg::CT_PLL] && valid_q;
         // Buck codes map to 0.7-3.36 V; step-up code n is 4.9+0.1n V.
         vset_o <= vset_q;
      end
   end

   // Cycles spent busy since the last start, for the length check.
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i)
         run_q <= 12'h000;
      else
         run_q <= (busy_q && !sel_wr) ? run_q + 12'h001 : 12'h000;
   end

   // Checks.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   chk_meas_start: assert property (sel_wr |=> busy_q)
      else $error("selection write did not start a reading");
   chk_meas_pwm: assert property (busy_q && !sel_q
      |=> buck_pwm_o[0])
      else $error("measured buck left PWM");
   chk_meas_len: assert property (run_q <= 12'(cmm_pkg::MEAS_CYC))
      else $error("reading overran its time");
   chk_flag_set: assert property (done |=> flag_q)
      else $error("done flag not set");
   chk_mask_gate: assert property (mask_q && $past(mask_q) |-> irq_n_o)
      else $error("masked completion reached the pin");
   chk_irq_pin: assert property (flag_q && !mask_q |=> !irq_n_o)
      else $error("unmasked flag did not drive the pin");
   chk_result_cap: assert property (done && !sel_wr
      |=> res_q == $past(meter_code_i))
      else $error("result not captured");
   chk_ss_range: assert property (spread_permille_o >= 10'd850
      && spread_permille_o <= 10'd1000)
      else $error("spread rate out of range");
   chk_ss_gate: assert property (!ss_on ##1 !ss_on
      |-> spread_permille_o == 10'd1000)
      else $error("spreading while disallowed");
   chk_fpwm_hold: assert property (fpwm_q[1] |=> buck_pwm_o[1])
      else $error("forced buck entered PFM");
   chk_boost_pwm: assert property (step_up_pwm_o)
      else $error("step-up left PWM");
   chk_bypass_fix: assert property (loaded_q |=> $stable(bypass_q))
      else $error("bypass choice changed");
   chk_ovp_fix: assert property (loaded_q |=> $stable(ovp_q))
      else $error("overvoltage choice changed");
   chk_sync_gate: assert property (use_sync_clock_o |-> $past(valid_q))
      else $error("invalid sync clock used");

   cov_meas_done: cover property (done);
   cov_clear_race: cover property (done && flag_clr);
   cov_ss_turn: cover property (ss_on && $rose(up_q));
   cov_sync_ok: cover property ($rose(use_sync_clock_o));
endmodule : cmm_top

// >>> logic/cmm_pkg.sv
// Shared constants for the converter mode and load meter block.
package cmm_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_VSET = 8'h04;
   localparam logic [7:0] OFS_SEL  = 8'h08;
   localparam logic [7:0] OFS_FLAG = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam logic [7:0] OFS_RLO  = 8'h14;
   localparam logic [7:0] OFS_RHI  = 8'h18;
   localparam logic [7:0] OFS_STAT = 8'h1C;
   // Control register fields.
   localparam int CT_SS    = 0;
   localparam int CT_PLL   = 1;
   localparam int CT_FPWM0 = 2;
   localparam int CT_FPWM1 = 3;
   localparam int CT_DIS   = 4;
   localparam int CT_BST   = 5;
   localparam int CT_RATE  = 6;
   localparam int RATE_W   = 5;
   localparam logic [15:0] CTRL_RST = 16'h0010;
   localparam logic [15:0] CTRL_MSK = 16'h07FF;
   // Voltage code register fields.
   localparam int VS_B0  = 0;
   localparam int VS_B1  = 8;
   localparam int VS_BST = 16;
   localparam int VS_LIM = 18;
   localparam logic [19:0] VSET_RST = 20'h0_0000;
   // Step-up target: 4.9 V plus 0.1 V per code step.
   localparam int BST_BASE_MV = 4900;
   localparam int BST_STEP_MV = 100;
   // Buck code segments: 10 mV to 0.73 V, 5 mV to 1.4 V, then 20 mV.
   localparam int BK_BASE_MV = 700;
   localparam int BK_KNEE1   = 730;
   localparam int BK_KNEE2   = 1400;
   localparam int BK_TOP_MV  = 3360;
   // Meter timing and scale.
   localparam int CLK_MHZ     = 40;
   localparam int MEAS_MAX_US = 50;
   localparam int MEAS_CYC    = MEAS_MAX_US * CLK_MHZ;
   localparam int RES_W       = 9;
   localparam int LSB_MA      = 20;
   localparam int FULL_MA     = ((1 << RES_W) - 1) * LSB_MA;
   // Spread spectrum: frequency swept from 850 to 1000 per mille.
   localparam int SS_LOW_PM  = 850;
   localparam int SS_HIGH_PM = 1000;
   localparam int SS_DIV     = 40;
   // Sync clock check window and tolerance in percent.
   localparam int WIN_US   = 10;
   localparam int WIN_CYC  = WIN_US * CLK_MHZ;
   localparam int TOL_LO   = 70;
   localparam int TOL_HI   = 110;
   localparam int RATE_MIN = 1;
   localparam int RATE_MAX = 24;
   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
endpackage : cmm_pkg

// >>> tb/cmm_host.sv
// Host model that masters the register bus of the block.
`timescale 1ns/1ps
module cmm_host (
   input  wire logic        core_clk_i,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   // The bus is idle from time zero.
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
   end

   // Handshakes are judged mid-cycle, where readies are settled, and
   // acted on at the following rising edge.
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            output logic [1:0] r);
      logic ta, tw, tb, done;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(negedge core_clk_i);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid & s_axi_bready;
         r = s_axi_bresp;
         @(posedge core_clk_i);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) done = 1'b1;
      end
   endtask : axi_write

   // Answer readies stay up once raised, so back-to-back calls never
   // drive them twice in one time step.
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      logic ta, tr, done;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(negedge core_clk_i);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid & s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge core_clk_i);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) done = 1'b1;
      end
   endtask : axi_read
endmodule : cmm_host

// >>> tb/cmm_top_bench.sv
// Self-checking testbench of the converter mode and load meter block.
`timescale 1ns/1ps
module cmm_top_bench;
   typedef struct packed {
      logic [7:0] a; logic [31:0] d; logic [1:0] heavy; logic [31:0] rd;
      logic [1:0] br; logic [1:0] rr; logic [1:0] pwm;
   } cmm_row_t;
   logic        core_clk_i, rstn_i, sync_on;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs, bs;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [19:0] otp_vset_i, vset_o;
   logic [1:0]  otp_fpwm_i, buck_heavy_i, buck_pwm_o;
   logic [8:0]  meter_code_i;
   logic [9:0]  spread_permille_o, lo, hi;
   logic        otp_bypass_i, input_overvoltage_choice_i, sync_clock_input_i;
   logic        step_up_pwm_o, step_up_discharge_o, step_up_bypass_o;
   logic        input_overvoltage_choice_o, use_sync_clock_o, irq_n_o;
   int          bad_count, check_count, n, sdiv;
   cmm_row_t    rows [12];

   cmm_top i_cmm_top (.core_clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .otp_vset_i, .otp_fpwm_i,
      .otp_bypass_i, .input_overvoltage_choice_i, .meter_code_i,
      .buck_heavy_i, .sync_clock_input_i, .buck_pwm_o, .step_up_pwm_o,
      .step_up_discharge_o, .step_up_bypass_o, .input_overvoltage_choice_o,
      .spread_permille_o, .use_sync_clock_o, .vset_o, .irq_n_o);
   cmm_host i_cmm_host (.core_clk_i, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   // The core clock runs at 40 MHz.
   always #12.5 core_clk_i = ~core_clk_i;

   // The external sync clock toggles every ten core cycles, so 2 MHz.
   always @(posedge core_clk_i) begin
      sdiv <= (sdiv == 9) ? 0 : sdiv + 1;
      if (sync_on && sdiv == 9)
         sync_clock_input_i <= ~sync_clock_input_i;
   end

   // Compares one value and reports a difference at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_cmm_host.axi_write(a, d, bs);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      i_cmm_host.axi_read(a, rd, rs);
      check(rd, exp);
   endtask : rchk

   // Counts cycles until the interrupt pin falls, with a bound.
   task automatic wait_irq();
      n = 0;
      while (irq_n_o !== 1'b0 && n < 3000) begin
         @(posedge core_clk_i);
         n++;
      end
   endtask : wait_irq

   // Writes a sync setting and checks the clock choice a while later.
   task automatic sync_case(input logic [31:0] ctrl, input logic exp);
      wr(cmm_pkg::OFS_CTRL, ctrl);
      repeat (1000) @(posedge core_clk_i);
      check(use_sync_clock_o, exp);
   endtask : sync_case

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // Cuts a hung run short.
   initial begin
      #(60000 * 25);
      bad_count++;
      print_verdict();
   end

   // Main sequence: reset, table rows, then the meter, spread and sync.
   initial begin
      {core_clk_i, rstn_i, sync_on, sync_clock_input_i, bad_count} = '0;
      {check_count, sdiv, meter_code_i, buck_heavy_i} = '0;
      otp_vset_i = 20'h3_C2A5;
      otp_fpwm_i = 2'b10;
      {otp_bypass_i, input_overvoltage_choice_i} = 2'b11;
      rows = '{
         '{8'h00, 32'h0000_0010, 2'b00, 32'h0000_0010, 2'b00, 2'b00, 2'b00},
         '{8'h00, 32'h0000_0010, 2'b01, 32'h0000_0010, 2'b00, 2'b00, 2'b01},
         '{8'h00, 32'h0000_0010, 2'b10, 32'h0000_0010, 2'b00, 2'b00, 2'b10},
         '{8'h00, 32'h0000_0014, 2'b00, 32'h0000_0014, 2'b00, 2'b00, 2'b01},
         '{8'h00, 32'h0000_0018, 2'b01, 32'h0000_0018, 2'b00, 2'b00, 2'b11},
         '{8'h00, 32'hFFFF_FFFF, 2'b00, 32'h0000_07FF, 2'b00, 2'b00, 2'b11},
         '{8'h04, 32'hFFF5_A3C7, 2'b00, 32'h0005_A3C7, 2'b00, 2'b00, 2'b11},
         '{8'h10, 32'h0000_0001, 2'b00, 32'h0000_0001, 2'b00, 2'b00, 2'b11},
         '{8'h10, 32'h0000_0000, 2'b00, 32'h0000_0000, 2'b00, 2'b00, 2'b11},
         '{8'h14, 32'h0000_00FF, 2'b00, 32'h0000_0000, 2'b10, 2'b00, 2'b11},
         '{8'h20, 32'h0000_0005, 2'b00, 32'h0000_0000, 2'b10, 2'b10, 2'b11},
         '{8'h00, 32'h0000_0010, 2'b00, 32'h0000_0010, 2'b00, 2'b00, 2'b00}};
      repeat (8) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      {otp_bypass_i, input_overvoltage_choice_i} <= 2'b00;
      repeat (4) @(posedge core_clk_i);
      check(vset_o, 20'h3_C2A5);
      check(buck_pwm_o, 2'b10);
      check(step_up_bypass_o, 1'b1);
      check(input_overvoltage_choice_o, 1'b1);
      check(step_up_discharge_o, 1'b1);
      rchk(cmm_pkg::OFS_CTRL, 32'h0000_0018);
      foreach (rows[k]) begin
         buck_heavy_i <= rows[k].heavy;
         wr(rows[k].a, rows[k].d);
         check(bs, rows[k].br);
         rchk(rows[k].a, rows[k].rd);
         check(rs, rows[k].rr);
         repeat (4) @(posedge core_clk_i);
         check(buck_pwm_o, rows[k].pwm);
         check(step_up_pwm_o, 1'b1);
      end
      check(vset_o, 20'h5_A3C7);
      check(step_up_discharge_o, 1'b1);
      wr(cmm_pkg::OFS_CTRL, 32'h0000_0000);
      repeat (2) @(posedge core_clk_i);
      check(step_up_discharge_o, 1'b0);
      // Unmasked reading of the second buck.
      meter_code_i <= 9'h1A5;
      wr(cmm_pkg::OFS_SEL, 32'h0000_0001);
      repeat (2) @(posedge core_clk_i);
      check(buck_pwm_o, 2'b10);
      wait_irq();
      check(n <= cmm_pkg::MEAS_CYC + 2, 1'b1);
      repeat (2) @(posedge core_clk_i);
      check(buck_pwm_o, 2'b00);
      rchk(cmm_pkg::OFS_FLAG, 32'h0000_0001);
      rchk(cmm_pkg::OFS_RLO, 32'h0000_00A5);
      rchk(cmm_pkg::OFS_RHI, 32'h0000_0001);
      wr(cmm_pkg::OFS_FLAG, 32'h0000_0001);
      repeat (3) @(posedge core_clk_i);
      check(irq_n_o, 1'b1);
      // Masked reading of the first buck.
      wr(cmm_pkg::OFS_MASK, 32'h0000_0001);
      meter_code_i <= 9'h0FF;
      wr(cmm_pkg::OFS_SEL, 32'h0000_0000);
      repeat (2) @(posedge core_clk_i);
      check(buck_pwm_o, 2'b01);
      repeat (cmm_pkg::MEAS_CYC + 10) @(posedge core_clk_i);
      check(irq_n_o, 1'b1);
      rchk(cmm_pkg::OFS_FLAG, 32'h0000_0001);
      rchk(cmm_pkg::OFS_RLO, 32'h0000_00FF);
      rchk(cmm_pkg::OFS_RHI, 32'h0000_0000);
      wr(cmm_pkg::OFS_FLAG, 32'h0000_0001);
      wr(cmm_pkg::OFS_MASK, 32'h0000_0000);
      // A selection written mid-reading starts the count again.
      wr(cmm_pkg::OFS_SEL, 32'h0000_0000);
      repeat (1000) @(posedge core_clk_i);
      wr(cmm_pkg::OFS_SEL, 32'h0000_0001);
      wait_irq();
      check(n > 1500 && n <= cmm_pkg::MEAS_CYC + 2, 1'b1);
      wr(cmm_pkg::OFS_FLAG, 32'h0000_0001);
      // Spreading sweeps the full band only with the PLL off.
      wr(cmm_pkg::OFS_CTRL, 32'h0000_0011);
      {lo, hi} = {10'd1000, 10'd0};
      repeat (13000) begin
         @(posedge core_clk_i);
         if (spread_permille_o < lo) lo = spread_permille_o;
         if (spread_permille_o > hi) hi = spread_permille_o;
      end
      check(lo, 10'd850);
      check(hi, 10'd1000);
      wr(cmm_pkg::OFS_CTRL, 32'h0000_0013);
      repeat (5) @(posedge core_clk_i);
      lo = 10'd1000;
      repeat (300) begin
         @(posedge core_clk_i);
         if (spread_permille_o !== 10'd1000) lo = spread_permille_o;
      end
      check(lo, 10'd1000);
      // Sync clock at 2 MHz against several nominal settings.
      sync_on <= 1'b1;
      sync_case(32'h0000_0092, 1'b1);
      sync_case(32'h0000_0052, 1'b0);
      sync_case(32'h0000_00D2, 1'b0);
      sync_case(32'h0000_0090, 1'b0);
      print_verdict();
   end
endmodule : cmm_top_bench
